// *** testbench/cpu_bus_model.sv ***
// cpu side of the register bus: single-cycle word or byte accesses
// assumes the block takes a request at the rising edge while req is high
`timescale 1ns/1ps
module cpu_bus_model
    import timer_cc_pkg::*;
(
    // clock and returned data
    input  wire logic        clock,
    input  wire logic [15:0] bus_rdata,
    // request toward the block
    output bus_req_type      bus_req
);
    initial bus_req = '0;

    // request stands for exactly the edge that takes it; released fields are
    // inverted so nothing can lean on stale write data
    task automatic access(input logic w, input logic [2:0] ch, input logic [1:0] sel,
                          input logic [1:0] be, input logic [15:0] wd,
                          output logic [15:0] rd);
        @(posedge clock);
        bus_req <= '{req: 1'b1, write: w, channel: ch, select: sel, byte_en: be, wdata: wd};
        @(posedge clock);
        bus_req <= {1'b0, ~bus_req[$bits(bus_req_type)-2:0]};
        @(negedge clock);
        rd = bus_rdata;
    endtask
endmodule

// *** testbench/timer_cc_properties.sv ***
// checker for the compare/capture block, watching its top-level ports
// assumes it is bound into every timer_compare_capture_regs instance
`timescale 1ns/1ps
`include "timer_cc_params.svh"
module timer_cc_properties
    import timer_cc_pkg::*;
#(
    parameter int CHANNELS = 5,
    parameter int WIDTH    = 16
) (
    // clock, reset and cpu bus
    input wire logic                            clock, rst_n, standby,
    input wire bus_req_type                     bus_req,
    input wire logic [WIDTH-1:0]                bus_rdata,
    // channel side
    input wire chan_cfg_type [CHANNELS-1:0]     chan_cfg,
    input wire logic [CHANNELS-1:0][WIDTH-1:0]  channel_counter,
    input wire logic [3:0]                      timer_function_control,
    input wire logic [CHANNELS-1:0]             capture_in_a, capture_in_b,
    input wire logic [CHANNELS-1:0]             match_capture_flag_a, match_capture_flag_b,
    input wire logic [CHANNELS-1:0]             counter_clear,
    input wire pin_action_type [CHANNELS-1:0]   pin_action_a, pin_action_b
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_standby_quiet;
        standby |=> match_capture_flag_a == '0 && match_capture_flag_b == '0 && counter_clear == '0;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("event after standby");

    property p_refused_read;
        bus_req.req && !bus_req.write &&
        (bus_req.channel > 3'h4 || (bus_req.select[1] && bus_req.channel < 3'h3))
        |=> bus_rdata == 16'hffff;
    endproperty
    a_refused_read: assert property (p_refused_read) else $error("absent register not ffff");

    // ----------------------------------------------------------------
    // per channel
    // ----------------------------------------------------------------
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        pin_action_type want_a;
        assign want_a = chan_cfg[i].pwm_mode ? 3'h0 :
                        chan_cfg[i].io_a == `IO_LOW ? 3'h2 : chan_cfg[i].io_a == `IO_HIGH ? 3'h4 :
                        chan_cfg[i].io_a == `IO_TOGGLE ? 3'h1 : 3'h0;
        property p_pin_code;
            pin_action_a[i] == 3'h0 || pin_action_a[i] == $past(want_a);
        endproperty
        a_pin_code: assert property (p_pin_code) else $error("pin action a off its io code");
        property p_pwm_quiet;
            $past(chan_cfg[i].pwm_mode) |-> pin_action_b[i] == 3'h0;
        endproperty
        a_pwm_quiet: assert property (p_pwm_quiet) else $error("pin action b in pwm mode");
        property p_pin_flag;
            pin_action_b[i] != 3'h0 |-> match_capture_flag_b[i];
        endproperty
        a_pin_flag: assert property (p_pin_flag) else $error("pin action b without flag");
        property p_clear;
            counter_clear[i] == (($past(chan_cfg[i].clear_sel) == `CLR_BY_A && match_capture_flag_a[i])
                              || ($past(chan_cfg[i].clear_sel) == `CLR_BY_B && match_capture_flag_b[i]));
        endproperty
        a_clear: assert property (p_clear) else $error("counter clear off its source");
        property p_cap_rise;
            $past(rst_n) && !$past(standby) && !standby && !chan_cfg[i].pwm_mode &&
            chan_cfg[i].io_a == `IO_RISE && $rose(capture_in_a[i]) |=> match_capture_flag_a[i];
        endproperty
        a_cap_rise: assert property (p_cap_rise) else $error("rising capture a missed");
        property p_cap_fall;
            $past(rst_n) && !$past(standby) && !standby && !chan_cfg[i].pwm_mode &&
            chan_cfg[i].io_b == `IO_FALL && $fell(capture_in_b[i]) |=> match_capture_flag_b[i];
        endproperty
        a_cap_fall: assert property (p_cap_fall) else $error("falling capture b missed");
    end
endmodule

bind timer_compare_capture_regs timer_cc_properties #(.CHANNELS(CHANNELS), .WIDTH(WIDTH)) props (
    .clock(clock), .rst_n(rst_n), .standby(standby), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .chan_cfg(chan_cfg), .channel_counter(channel_counter),
    .timer_function_control(timer_function_control), .capture_in_a(capture_in_a),
    .capture_in_b(capture_in_b), .match_capture_flag_a(match_capture_flag_a),
    .match_capture_flag_b(match_capture_flag_b), .counter_clear(counter_clear),
    .pin_action_a(pin_action_a), .pin_action_b(pin_action_b));

// *** testbench/timer_compare_capture_regs_tb_top.sv ***
// self-checking bench for the timer compare/capture register block
// assumes the cpu model and the bound checker are compiled alongside
`timescale 1ns/1ps
`include "timer_cc_params.svh"
module timer_compare_capture_regs_tb_top
    import timer_cc_pkg::*;
;
    typedef struct packed {
        logic [2:0]  ch;
        logic [1:0]  sel;
        logic [1:0]  be;
        logic [15:0] wd;
        logic [15:0] exp;
    } row_type;
    logic                 clock, rst_n, standby;
    bus_req_type          bus_req;
    logic [15:0]          bus_rdata, rd;
    chan_cfg_type [4:0]   chan_cfg;
    logic [4:0][15:0]     channel_counter;
    logic [3:0]           buffer_enables;
    logic [4:0]           capture_in_a, capture_in_b, flag_a, flag_b, counter_clear;
    pin_action_type [4:0] pin_action_a, pin_action_b;
    int                   miscompares, n_compared, cycles;
    // byte writes leave the other byte at its reset ones
    row_type rows[7] = '{'{3'h0, `SEL_CC_A, 2'h3, 16'h1234, 16'h1234},
        '{3'h1, `SEL_CC_B, 2'h1, 16'h00ab, 16'hffab}, '{3'h2, `SEL_CC_A, 2'h2, 16'hcd00, 16'hcdff},
        '{3'h3, `SEL_SHADOW_A, 2'h3, 16'h5a5a, 16'h5a5a},
        '{3'h4, `SEL_SHADOW_B, 2'h2, 16'h3c00, 16'h3cff},
        '{3'h0, `SEL_SHADOW_A, 2'h3, 16'h0000, 16'hffff}, '{3'h5, `SEL_CC_A, 2'h3, 16'h0000, 16'hffff}};
    // {pwm, io code, expected {set, clr, toggle}}
    logic [6:0] match_rows[5] = '{{1'b0, `IO_LOW, 3'h2}, {1'b0, `IO_HIGH, 3'h4},
        {1'b0, `IO_TOGGLE, 3'h1}, {1'b0, `IO_NONE, 3'h0}, {1'b1, `IO_TOGGLE, 3'h0}};

    timer_compare_capture_regs #(.CHANNELS(5), .WIDTH(16)) DUT (
        .clock(clock), .rst_n(rst_n), .standby(standby), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .chan_cfg(chan_cfg), .channel_counter(channel_counter),
        .timer_function_control(buffer_enables), .capture_in_a(capture_in_a),
        .capture_in_b(capture_in_b), .match_capture_flag_a(flag_a), .match_capture_flag_b(flag_b),
        .counter_clear(counter_clear), .pin_action_a(pin_action_a), .pin_action_b(pin_action_b));
    cpu_bus_model cpu (.clock(clock), .bus_rdata(bus_rdata), .bus_req(bus_req));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input string what, input logic [2:0] ch, input logic [1:0] sel,
                          input logic [15:0] exp);
        cpu.access(1'b0, ch, sel, 2'h3, 16'h0000, rd);
        check(what, exp, rd);
    endtask
    // counter sits on the value for one cycle only, so one pulse is expected
    task automatic hit(input int ch, input logic [15:0] v);
        channel_counter[ch] <= v;
        @(posedge clock);
        channel_counter[ch] <= 16'h0000;
        @(negedge clock);
    endtask
    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            results();
        end
    end

    initial begin
        {rst_n, standby, buffer_enables, capture_in_a, capture_in_b} = '0;
        chan_cfg = '0;
        channel_counter = '0;
        {miscompares, n_compared, cycles} = '0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        for (int c = 0; c < 5; c++)
            for (int s = 0; s < 4; s++)
                rd_chk("reset value", 3'(c), 2'(s), 16'hffff);
        foreach (rows[k]) begin
            cpu.access(1'b1, rows[k].ch, rows[k].sel, rows[k].be, rows[k].wd, rd);
            rd_chk("register row", rows[k].ch, rows[k].sel, rows[k].exp);
        end
        $display("test reset and register access done");
        foreach (match_rows[k]) begin
            @(posedge clock);
            chan_cfg[0] <= '{match_rows[k][5:3], `IO_NONE, `CLR_BY_A, match_rows[k][6]};
            hit(0, 16'h1234);
            check("match flag a", 16'h0001, 16'(flag_a[0]));
            check("pin action a", 16'(match_rows[k][2:0]), 16'(pin_action_a[0]));
            check("counter clear", 16'h0001, 16'(counter_clear[0]));
            @(negedge clock);
            check("match flag a drop", 16'h0000, 16'(flag_a[0]));
        end
        $display("test compare match done");
        @(posedge clock);
        chan_cfg[1].io_b <= `IO_RISE;
        channel_counter[1] <= 16'h4321;
        @(posedge clock);
        capture_in_b[1] <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        check("capture flag b", 16'h0001, 16'(flag_b[1]));
        rd_chk("captured b", 3'h1, `SEL_CC_B, 16'h4321);
        @(posedge clock);
        buffer_enables <= 4'h1;
        hit(3, 16'hffff);
        rd_chk("reloaded compare a", 3'h3, `SEL_CC_A, 16'h5a5a);
        @(posedge clock);
        buffer_enables <= 4'h8;
        chan_cfg[4].io_b <= `IO_FALL;
        capture_in_b[4] <= 1'b1;
        channel_counter[4] <= 16'h0777;
        repeat (2) @(posedge clock);
        capture_in_b[4] <= 1'b0;
        @(posedge clock);
        @(negedge clock);
        check("capture flag b4", 16'h0001, 16'(flag_b[4]));
        rd_chk("captured b4", 3'h4, `SEL_CC_B, 16'h0777);
        rd_chk("shadow b4", 3'h4, `SEL_SHADOW_B, 16'hffff);
        @(posedge clock);
        chan_cfg[2].io_a <= `IO_RISE;
        channel_counter[2] <= 16'h0abc;
        @(posedge clock);
        capture_in_a[2] <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        check("capture flag a2", 16'h0001, 16'(flag_a[2]));
        rd_chk("captured a2", 3'h2, `SEL_CC_A, 16'h0abc);
        $display("test capture and buffering done");
        @(posedge clock);
        standby <= 1'b1;
        @(posedge clock);
        standby <= 1'b0;
        rd_chk("compare a after standby", 3'h0, `SEL_CC_A, 16'hffff);
        rd_chk("shadow a after standby", 3'h3, `SEL_SHADOW_A, 16'hffff);
        $display("test standby done");
        results();
    end
endmodule

// *** verilog/timer_cc_params.svh ***
// constants for the timer compare/capture register block
// assumes inclusion by the package, the checker and the bench top
`ifndef TIMER_CC_PARAMS_SVH
`define TIMER_CC_PARAMS_SVH

`define CC_RESET_VALUE   16'hffff
`define SHADOW_RESET     16'hffff
`define CHANNEL_COUNT    5
`define FIRST_BUF_CH     3
// register select codes on the internal bus, per channel
`define SEL_CC_A         2'h0
`define SEL_CC_B         2'h1
`define SEL_SHADOW_A     2'h2
`define SEL_SHADOW_B     2'h3
// pin io control field layout (per general register, 3 bits)
`define IO_CAPTURE_BIT   2
`define IO_NONE          3'h0
`define IO_LOW           3'h1
`define IO_HIGH          3'h2
`define IO_TOGGLE        3'h3
`define IO_RISE          3'h4
`define IO_FALL          3'h5
// counter clear select
`define CLR_NONE         2'h0
`define CLR_BY_A         2'h1
`define CLR_BY_B         2'h2

`endif

// *** verilog/timer_cc_pkg.sv ***
// types shared by the timer compare/capture block and its bench
// assumes timer_cc_params.svh is on the include path
package timer_cc_pkg;
    `include "timer_cc_params.svh"

    typedef struct packed {
        logic        req;
        logic        write;
        logic [2:0]  channel;
        logic [1:0]  select;
        logic [1:0]  byte_en;   // bit1 upper byte, bit0 lower byte
        logic [15:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic [2:0]  io_a;
        logic [2:0]  io_b;
        logic [1:0]  clear_sel;
        logic        pwm_mode;
    } chan_cfg_type;

    typedef struct packed {
        logic        set_level;
        logic        clr_level;
        logic        toggle;
    } pin_action_type;
endpackage

// *** verilog/timer_compare_capture_regs.sv ***
// compare/capture registers of a five channel 16-bit timer unit
// assumes counters, edge pins and status flags live outside; cpu bus is
// synchronous, single cycle, 16 bits wide with two byte enables
//
// How it works
// - two 16-bit registers per channel, five channels
// - io control picks compare or capture role
// - compare equality sets the a/b flag
// - pin action on match per io setting
// - selected edge captures counter and sets flag
// - io settings ignored in pwm modes
// - cpu word or byte access to registers
// - reset/standby: all ones, compare, no output
// - buffer registers only in channels 3, 4
// - each buffer has own enable bit
// - compare buffer copies in on match
// - buffer role follows its paired register
// - cpu word or byte access to buffers
// - buffers reset to all ones
// - match or capture may clear the counter
`timescale 1ns/1ps

module timer_compare_capture_regs
    import timer_cc_pkg::*;
#(
    parameter int CHANNELS = `CHANNEL_COUNT,
    parameter int WIDTH    = 16
) (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic                          standby,
    // cpu register bus
    input  wire bus_req_type                   bus_req,
    output logic [WIDTH-1:0]                   bus_rdata,
    // per channel configuration and counter
    input  wire chan_cfg_type [CHANNELS-1:0]   chan_cfg,
    input  wire logic [CHANNELS-1:0][WIDTH-1:0] channel_counter,
    // buffer enables: {b_ch4, a_ch4, b_ch3, a_ch3}
    input  wire logic [3:0]                    timer_function_control,
    // capture inputs, one sample per cycle
    input  wire logic [CHANNELS-1:0]           capture_in_a,
    input  wire logic [CHANNELS-1:0]           capture_in_b,
    // events toward status register, counter and pins
    output logic [CHANNELS-1:0]                match_capture_flag_a,
    output logic [CHANNELS-1:0]                match_capture_flag_b,
    output logic [CHANNELS-1:0]                counter_clear,
    output pin_action_type [CHANNELS-1:0]      pin_action_a,
    output pin_action_type [CHANNELS-1:0]      pin_action_b
);

    logic [CHANNELS-1:0][WIDTH-1:0] compare_capture_reg_a;
    logic [CHANNELS-1:0][WIDTH-1:0] compare_capture_reg_b;
    logic [CHANNELS-1:0][WIDTH-1:0] shadow_reg_a;
    logic [CHANNELS-1:0][WIDTH-1:0] shadow_reg_b;
    logic [CHANNELS-1:0]            prev_in_a;
    logic [CHANNELS-1:0]            prev_in_b;
    logic [CHANNELS-1:0]            event_a;
    logic [CHANNELS-1:0]            event_b;

    // byte merge for partial writes
    function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old,
                                               input logic [WIDTH-1:0] wd,
                                               input logic [1:0]       be);
        logic [WIDTH-1:0] r;
        r = old;
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        return r;
    endfunction

    // edge detect for a capture role io code
    function automatic logic edge_hit(input logic [2:0] io,
                                      input logic       cur,
                                      input logic       prev);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        if (io == `IO_RISE) begin
            edge_hit = rise;
        end else if (io == `IO_FALL) begin
            edge_hit = fall;
        end else begin
            edge_hit = rise | fall;
        end
    endfunction

    // io action decode, silenced in pwm modes where io control is ignored
    function automatic pin_action_type action(input logic [2:0] io,
                                              input logic       hit,
                                              input logic       pwm);
        pin_action_type p;
        p = '0;
        if (hit && !pwm && !io[`IO_CAPTURE_BIT]) begin
            p.clr_level = (io == `IO_LOW);
            p.set_level = (io == `IO_HIGH);
            p.toggle    = (io == `IO_TOGGLE);
        end
        return p;
    endfunction

    // ------------------------------------------------------------------
    // per channel compare and capture
    // ------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            logic cap_a;
            logic cap_b;
            logic hit_a;
            logic hit_b;
            logic buf_a;
            logic buf_b;
            logic wr_sel;

            // in pwm mode the registers stay in compare role
            assign cap_a = chan_cfg[ch].io_a[`IO_CAPTURE_BIT] &
                           ~chan_cfg[ch].pwm_mode;
            assign cap_b = chan_cfg[ch].io_b[`IO_CAPTURE_BIT] &
                           ~chan_cfg[ch].pwm_mode;
            assign hit_a = cap_a ? edge_hit(chan_cfg[ch].io_a, capture_in_a[ch],
                                            prev_in_a[ch])
                                 : (compare_capture_reg_a[ch] == channel_counter[ch]);
            assign hit_b = cap_b ? edge_hit(chan_cfg[ch].io_b, capture_in_b[ch],
                                            prev_in_b[ch])
                                 : (compare_capture_reg_b[ch] == channel_counter[ch]);
            assign event_a[ch] = hit_a;
            assign event_b[ch] = hit_b;
            assign wr_sel = bus_req.req & bus_req.write &
                            (bus_req.channel == 3'(ch));
            if (ch >= `FIRST_BUF_CH) begin : g_buf
                assign buf_a = timer_function_control[2*(ch-`FIRST_BUF_CH)];
                assign buf_b = timer_function_control[2*(ch-`FIRST_BUF_CH)+1];
            end else begin : g_nobuf
                assign buf_a = 1'b0;
                assign buf_b = 1'b0;
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    prev_in_a[ch] <= 1'b0;
                    prev_in_b[ch] <= 1'b0;
                end else begin
                    prev_in_a[ch] <= capture_in_a[ch];
                    prev_in_b[ch] <= capture_in_b[ch];
                end
            end

            // hardware update wins over a cpu write in the same cycle
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    compare_capture_reg_a[ch] <= `CC_RESET_VALUE;
                    compare_capture_reg_b[ch] <= `CC_RESET_VALUE;
                end else if (standby) begin
                    compare_capture_reg_a[ch] <= `CC_RESET_VALUE;
                    compare_capture_reg_b[ch] <= `CC_RESET_VALUE;
                end else begin
                    if (hit_a && cap_a) begin
                        compare_capture_reg_a[ch] <= channel_counter[ch];
                    end else if (hit_a && buf_a) begin
                        compare_capture_reg_a[ch] <= shadow_reg_a[ch];
                    end else if (wr_sel && bus_req.select == `SEL_CC_A) begin
                        compare_capture_reg_a[ch] <= merge(compare_capture_reg_a[ch],
                                                           bus_req.wdata,
                                                           bus_req.byte_en);
                    end
                    if (hit_b && cap_b) begin
                        compare_capture_reg_b[ch] <= channel_counter[ch];
                    end else if (hit_b && buf_b) begin
                        compare_capture_reg_b[ch] <= shadow_reg_b[ch];
                    end else if (wr_sel && bus_req.select == `SEL_CC_B) begin
                        compare_capture_reg_b[ch] <= merge(compare_capture_reg_b[ch],
                                                           bus_req.wdata,
                                                           bus_req.byte_en);
                    end
                end
            end

            // channels without buffering keep constant shadows, reading all ones
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    shadow_reg_a[ch] <= `SHADOW_RESET;
                    shadow_reg_b[ch] <= `SHADOW_RESET;
                end else if (standby || ch < `FIRST_BUF_CH) begin
                    shadow_reg_a[ch] <= `SHADOW_RESET;
                    shadow_reg_b[ch] <= `SHADOW_RESET;
                end else begin
                    if (hit_a && cap_a && buf_a) begin
                        shadow_reg_a[ch] <= compare_capture_reg_a[ch];
                    end else if (wr_sel && bus_req.select == `SEL_SHADOW_A) begin
                        shadow_reg_a[ch] <= merge(shadow_reg_a[ch], bus_req.wdata,
                                                  bus_req.byte_en);
                    end
                    if (hit_b && cap_b && buf_b) begin
                        shadow_reg_b[ch] <= compare_capture_reg_b[ch];
                    end else if (wr_sel && bus_req.select == `SEL_SHADOW_B) begin
                        shadow_reg_b[ch] <= merge(shadow_reg_b[ch], bus_req.wdata,
                                                  bus_req.byte_en);
                    end
                end
            end

            // ----------------------------------------------------------
            // events out: flags, pins and counter clear
            // ----------------------------------------------------------
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    match_capture_flag_a[ch] <= 1'b0;
                    match_capture_flag_b[ch] <= 1'b0;
                    counter_clear[ch]        <= 1'b0;
                    pin_action_a[ch]         <= '0;
                    pin_action_b[ch]         <= '0;
                end else if (standby) begin
                    match_capture_flag_a[ch] <= 1'b0;
                    match_capture_flag_b[ch] <= 1'b0;
                    counter_clear[ch]        <= 1'b0;
                    pin_action_a[ch]         <= '0;
                    pin_action_b[ch]         <= '0;
                end else begin
                    match_capture_flag_a[ch] <= hit_a;
                    match_capture_flag_b[ch] <= hit_b;
                    counter_clear[ch] <=
                        (chan_cfg[ch].clear_sel == `CLR_BY_A && hit_a) ||
                        (chan_cfg[ch].clear_sel == `CLR_BY_B && hit_b);
                    pin_action_a[ch] <= action(chan_cfg[ch].io_a, hit_a,
                                               chan_cfg[ch].pwm_mode);
                    pin_action_b[ch] <= action(chan_cfg[ch].io_b, hit_b,
                                               chan_cfg[ch].pwm_mode);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // read path, registered so data is steady one cycle after the request
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] next_rdata;

    always_comb begin
        next_rdata = '1;
        if (bus_req.channel < 3'(CHANNELS)) begin
            unique case (bus_req.select)
                `SEL_CC_A:     next_rdata = compare_capture_reg_a[bus_req.channel];
                `SEL_CC_B:     next_rdata = compare_capture_reg_b[bus_req.channel];
                `SEL_SHADOW_A: next_rdata = shadow_reg_a[bus_req.channel];
                `SEL_SHADOW_B: next_rdata = shadow_reg_b[bus_req.channel];
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= '0;
        end else if (bus_req.req && !bus_req.write) begin
            bus_rdata <= next_rdata;
        end
    end

endmodule
